// file: design/bss_core.v
// buck controller sequencer: gate commands, soft-start, protection, regs
`timescale 1ns/100ps
`default_nettype none

`include "bss_defines.vh"

// How it works
// - each switching tick starts high side; pwm comparator or max duty ends it.
// - valley limit at tick skips high-side turn-on, low side stays on.
// - after startup the low side is the complement of the high side.
// - a gate rises only after the opposite driver reports off.
// - enable starts a 64-step reference ramp lasting 2048 switching cycles.
// - enable low ramps reference down, then both gates go off.
// - soft-start unfinished after 4096 cycles turns both gates off.
// - after timeout stay off 8192 cycles, then soft-start again.
// - power-good released above 93 percent, pulled low below 90 percent.
// - power-good held low during the whole off period after a fault.
// - gates stay off until reference passes feedback and pwm asks.
// - an output above set point is pulled down only after the ramp.
// - during that pull-down the sink limit setting rises gradually.
// - supply lockout acts as a disable.
// - 3-bit valley counter up/down per cycle; at 111 stop and wait.
// - sink limit during low-side on turns low side off.
// - thermal shutdown forces gates low, resets soft-start, restarts after.
// - during supply lockout both gate commands stay low.
module bss_core #(
    parameter SW_PERIOD = 200,
    parameter MAX_ON    = 170,
    parameter OFF_CYC   = `BSS_OFF_CYC
) (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire        enable_in,
    input  wire        pwm_on_in,
    input  wire        valley_lim_in,
    input  wire        sink_lim_in,
    input  wire        fb_above_93_in,
    input  wire        fb_below_90_in,
    input  wire        ref_above_fb_in,
    input  wire        supply_lockout,
    input  wire        thermal_shdn_in,
    input  wire        hs_off_fb,
    input  wire        ls_off_fb,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         high_side_gate_cmd,
    output reg         low_side_gate_cmd,
    output reg         output_ok_flag_o,
    output reg         output_ok_flag_oe,
    output reg  [3:0]  sink_limit_level,
    output wire [6:0]  ref_level
);

    localparam [2:0] S_OFF  = 3'h0;
    localparam [2:0] S_UP   = 3'h1;
    localparam [2:0] S_RUN  = 3'h2;
    localparam [2:0] S_DOWN = 3'h3;
    localparam [2:0] S_HOLD = 3'h4;

    localparam [15:0] SW_LAST  = SW_PERIOD - 1;
    localparam [15:0] ON_LAST  = MAX_ON - 1;
    localparam [12:0] TMO_LAST = `BSS_SS_TIMEOUT - 1;
    localparam [13:0] OFF_LAST = OFF_CYC - 1;
    localparam [13:0] HIC_LAST = `BSS_HICCUP_WAIT - 1;
    localparam [4:0]  SNK_LAST = `BSS_SINK_STEP_CYC - 1;

    // =============================================
    // reset release
    reg rst_meta_reg;
    reg rst_n_reg;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // =============================================
    // input synchronisers
    wire [10:0] s_in;
    bss_sync #(.W(11)) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n_reg),
        .async_in ({enable_in, pwm_on_in, valley_lim_in, sink_lim_in,
                    fb_above_93_in, fb_below_90_in, ref_above_fb_in,
                    supply_lockout, thermal_shdn_in, hs_off_fb,
                    ls_off_fb}),
        .sync_out (s_in)
    );
    wire s_en     = s_in[10];
    wire s_pwm    = s_in[9];
    wire s_valley = s_in[8];
    wire s_sink   = s_in[7];
    wire s_pg_hi  = s_in[6];
    wire s_pg_lo  = s_in[5];
    wire s_ref_gt = s_in[4];
    wire s_lock   = s_in[3];
    wire s_therm  = s_in[2];
    wire s_hs_off = s_in[1];
    wire s_ls_off = s_in[0];

    // =============================================
    // switching clock divider
    reg  [15:0] sw_cnt_reg;
    wire        tick = (sw_cnt_reg == 16'h0000);
    always @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg)
            sw_cnt_reg <= 16'h0000;
        else if (sw_cnt_reg == SW_LAST)
            sw_cnt_reg <= 16'h0000;
        else
            sw_cnt_reg <= sw_cnt_reg + 16'h0001;
    end

    // =============================================
    // state and shared status
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg         ctrl_en_reg;
    reg  [12:0] tmo_reg;
    reg  [13:0] wait_reg;
    reg  [13:0] wait_last_reg;
    reg  [2:0]  hic_reg;
    reg         started_reg;
    reg         hs_phase_reg;
    reg         ls_blk_reg;
    reg  [4:0]  snk_div_reg;
    reg  [`BSS_FLT_W-1:0] flt_reg;

    // lockout treated as a disable, like thermal shutdown
    wire fault    = s_lock | s_therm;
    wire run_en   = s_en & ctrl_en_reg;
    wire hic_trip = (hic_reg == `BSS_HICCUP_MAX);
    wire tmo_hit  = tick & (tmo_reg == TMO_LAST);
    wire switching = ~fault &
                     ((state_reg == S_UP) | (state_reg == S_RUN) |
                      (state_reg == S_DOWN));
    wire at_top;
    wire at_zero;

    // =============================================
    // reference ramp
    // 64 steps over 2048 cycles
    bss_ramp u_ramp (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n_reg),
        .tick      (tick),
        .go_up     (state_reg == S_UP),
        .go_down   (state_reg == S_DOWN),
        .hold      (s_valley),
        .clear     (fault | (state_reg == S_OFF) | (state_reg == S_HOLD)),
        .level_reg (ref_level),
        .at_top    (at_top),
        .at_zero   (at_zero)
    );

    // =============================================
    // sequencing state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_OFF: begin
                if (run_en)
                    state_next = S_UP;
            end
            S_UP: begin
                if (!run_en)
                    state_next = S_DOWN;
                else if (tmo_hit || hic_trip)
                    state_next = S_HOLD;
                else if (at_top)
                    state_next = S_RUN;
            end
            S_RUN: begin
                if (hic_trip)
                    state_next = S_HOLD;
                else if (!run_en)
                    state_next = S_DOWN;
            end
            S_DOWN: begin
                if (hic_trip)
                    state_next = S_HOLD;
                else if (at_zero)
                    state_next = S_OFF;
                else if (run_en)
                    state_next = S_UP;
            end
            S_HOLD: begin
                if (tick && (wait_reg == wait_last_reg))
                    state_next = S_OFF;
            end
            default: state_next = S_OFF;
        endcase
        if (fault)
            state_next = S_OFF;
    end

    always @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg     <= S_OFF;
            tmo_reg       <= 13'h0000;
            wait_reg      <= 14'h0000;
            wait_last_reg <= 14'h0000;
        end else begin
            state_reg <= state_next;
            if (state_reg != S_UP)
                tmo_reg <= 13'h0000;
            else if (tick)
                tmo_reg <= tmo_reg + 13'h0001;
            if (state_next == S_HOLD && state_reg != S_HOLD) begin
                wait_reg      <= 14'h0000;
                // counter at 111 waits the hiccup delay
                wait_last_reg <= hic_trip ? HIC_LAST : OFF_LAST;
            end else if (tick) begin
                wait_reg <= wait_reg + 14'h0001;
            end
        end
    end

    // =============================================
    // hiccup counter, startup flag, sink ramp
    always @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            hic_reg          <= 3'h0;
            started_reg      <= 1'b0;
            sink_limit_level <= 4'h0;
            snk_div_reg      <= 5'h00;
        end else if (!switching) begin
            hic_reg          <= 3'h0;
            started_reg      <= 1'b0;
            sink_limit_level <= 4'h0;
            snk_div_reg      <= 5'h00;
        end else begin
            if (tick && s_valley && !hic_trip)
                hic_reg <= hic_reg + 3'h1;
            else if (tick && !s_valley && hic_reg != 3'h0)
                hic_reg <= hic_reg - 3'h1;
            // first pulse once reference passes feedback
            // prebiased output starts pulling down after ramp
            if ((tick && s_ref_gt && s_pwm) || state_reg == S_RUN)
                started_reg <= 1'b1;
            // sink limit raised step by step after the ramp
            if (state_reg == S_RUN && tick &&
                sink_limit_level != `BSS_SINK_MAX) begin
                if (snk_div_reg == SNK_LAST) begin
                    snk_div_reg      <= 5'h00;
                    sink_limit_level <= sink_limit_level + 4'h1;
                end else begin
                    snk_div_reg <= snk_div_reg + 5'h01;
                end
            end
        end
    end

    // =============================================
    // per-cycle gate sequencing
    wire hs_start = tick & switching & started_reg & s_pwm & ~s_valley;
    wire hs_end   = ~s_pwm | (sw_cnt_reg == ON_LAST);

    always @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            hs_phase_reg       <= 1'b0;
            ls_blk_reg         <= 1'b0;
            high_side_gate_cmd <= 1'b0;
            low_side_gate_cmd  <= 1'b0;
        end else begin
            if (hs_start)
                hs_phase_reg <= 1'b1;
            else if (!switching || tick || hs_end)
                hs_phase_reg <= 1'b0;
            // sink trip blocks the low side until next tick
            if (tick || !switching)
                ls_blk_reg <= 1'b0;
            else if (s_sink && low_side_gate_cmd)
                ls_blk_reg <= 1'b1;
            // adaptive dead time on both edges
            // no switching unless sequencing allows it
            high_side_gate_cmd <= switching & hs_phase_reg &
                                  ~low_side_gate_cmd & s_ls_off;
            low_side_gate_cmd  <= switching & started_reg &
                                  ~hs_phase_reg & ~ls_blk_reg &
                                  ~(s_sink & low_side_gate_cmd) &
                                  ~high_side_gate_cmd & s_hs_off;
        end
    end

    // =============================================
    // power-good, open drain
    always @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            output_ok_flag_o  <= 1'b0;
            output_ok_flag_oe <= 1'b1;
        end else begin
            output_ok_flag_o <= 1'b0;
            // held low off and through the hold period
            if (!switching)
                output_ok_flag_oe <= 1'b1;
            // release above 93, pull low below 90
            else if (s_pg_hi)
                output_ok_flag_oe <= 1'b0;
            else if (s_pg_lo)
                output_ok_flag_oe <= 1'b1;
        end
    end

    // =============================================
    // avalon-mm slave, one wait state
    wire       req    = avs_read | avs_write;
    wire       take   = req & ~avs_waitrequest;
    wire       do_wr  = avs_write & take;
    wire [`BSS_FLT_W-1:0] flt_set = {
        s_lock, s_therm,
        s_sink & low_side_gate_cmd,
        (state_reg != S_HOLD) & (state_next == S_HOLD) & hic_trip,
        (state_reg == S_UP) & tmo_hit};
    wire [`BSS_FLT_W-1:0] flt_clr =
        (do_wr && avs_address == `BSS_OFS_FAULT && avs_byteenable[0]) ?
        avs_writedata[`BSS_FLT_W-1:0] : {`BSS_FLT_W{1'b0}};
    reg  [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `BSS_OFS_CTRL: rd_mux[`BSS_CTRL_EN_BIT] = ctrl_en_reg;
            `BSS_OFS_STATUS: begin
                rd_mux[`BSS_STAT_LVL_LSB +: 7] = ref_level;
                rd_mux[`BSS_STAT_PG_BIT]       = ~output_ok_flag_oe;
                rd_mux[`BSS_STAT_HIC_LSB +: 3] = hic_reg;
                rd_mux[`BSS_STAT_ST_BIT]       = started_reg;
                rd_mux[`BSS_STAT_FSM_LSB +: 3] = state_reg;
            end
            `BSS_OFS_FAULT: rd_mux[`BSS_FLT_W-1:0] = flt_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            ctrl_en_reg     <= `BSS_CTRL_RST;
            flt_reg         <= {`BSS_FLT_W{1'b0}};
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read && avs_waitrequest)
                avs_readdata <= rd_mux;
            if (do_wr && avs_address == `BSS_OFS_CTRL && avs_byteenable[0])
                ctrl_en_reg <= avs_writedata[`BSS_CTRL_EN_BIT];
            // set wins over a write-one clear
            flt_reg <= (flt_reg & ~flt_clr) | flt_set;
        end
    end

endmodule

`default_nettype wire

// file: design/bss_ramp.v
// stepped reference ramp for soft-start and soft-stop
`timescale 1ns/100ps
`default_nettype none

`include "bss_defines.vh"

module bss_ramp #(
    parameter STEPS    = `BSS_RAMP_STEPS,
    parameter STEP_CYC = `BSS_STEP_CYC,
    parameter LW       = 7
) (
    input  wire          clk_sys,
    input  wire          rst_n,
    input  wire          tick,
    input  wire          go_up,
    input  wire          go_down,
    input  wire          hold,
    input  wire          clear,
    output reg  [LW-1:0] level_reg,
    output wire          at_top,
    output wire          at_zero
);

    localparam [LW-1:0] TOP    = STEPS;
    localparam [15:0]   DIVMAX = STEP_CYC - 1;

    reg  [15:0] div_reg;
    wire        move;

    assign at_top  = (level_reg == TOP);
    assign at_zero = (level_reg == {LW{1'b0}});
    // a held ramp stalls, which is what lets the startup timeout expire
    assign move    = tick & ~hold &
                     ((go_up & ~at_top) | (go_down & ~at_zero));

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg   <= 16'h0000;
            level_reg <= {LW{1'b0}};
        end else if (clear) begin
            div_reg   <= 16'h0000;
            level_reg <= {LW{1'b0}};
        end else if (move) begin
            if (div_reg == DIVMAX) begin
                div_reg <= 16'h0000;
                if (go_up)
                    level_reg <= level_reg + {{(LW-1){1'b0}}, 1'b1};
                else
                    level_reg <= level_reg - {{(LW-1){1'b0}}, 1'b1};
            end else begin
                div_reg <= div_reg + 16'h0001;
            end
        end
    end

endmodule

`default_nettype wire

// file: design/bss_sync.v
// two-flop synchroniser bank for comparator and pin inputs
`timescale 1ns/100ps
`default_nettype none

module bss_sync #(
    parameter W = 11
) (
    input  wire         clk_sys,
    input  wire         rst_n,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // =============================================
    // one pair of flops per bit
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_reg;

endmodule

`default_nettype wire

// file: pkg/bss_defines.vh
// constants of the buck soft-start pwm sequencer
`ifndef BSS_DEFINES_VH
`define BSS_DEFINES_VH

// =============================================
// register map (byte addresses)
`define BSS_OFS_CTRL      4'h0
`define BSS_OFS_STATUS    4'h4
`define BSS_OFS_FAULT     4'h8

// =============================================
// field positions and reset values
`define BSS_CTRL_EN_BIT   0
`define BSS_CTRL_RST      1'b1
`define BSS_FLT_TMO_BIT   0
`define BSS_FLT_HIC_BIT   1
`define BSS_FLT_SINK_BIT  2
`define BSS_FLT_THERM_BIT 3
`define BSS_FLT_LOCK_BIT  4
`define BSS_FLT_W         5
`define BSS_STAT_LVL_LSB  0
`define BSS_STAT_PG_BIT   8
`define BSS_STAT_HIC_LSB  12
`define BSS_STAT_ST_BIT   16
`define BSS_STAT_FSM_LSB  20

// =============================================
// timing, in switching cycles
`define BSS_RAMP_STEPS    64
`define BSS_RAMP_CYC      2048
`define BSS_STEP_CYC      (`BSS_RAMP_CYC / `BSS_RAMP_STEPS)
`define BSS_SS_TIMEOUT    4096
`define BSS_HICCUP_WAIT   4096
`define BSS_OFF_CYC       8192
`define BSS_HICCUP_MAX    3'h7
`define BSS_SINK_MAX      4'hf
`define BSS_SINK_STEP_CYC 16

`endif

// file: tb/bss_core_asserts.sv
// port checker for the buck soft-start pwm sequencer
`timescale 1ns/100ps
`default_nettype none
// ==========
// checker
module bss_core_asserts #(
    parameter MAX_ON = 170
) (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       valley_lim_in,
    input wire logic       sink_lim_in,
    input wire logic       fb_below_90_in,
    input wire logic       supply_lockout,
    input wire logic       thermal_shdn_in,
    input wire logic       high_side_gate_cmd,
    input wire logic       low_side_gate_cmd,
    input wire logic       output_ok_flag_o,
    input wire logic       output_ok_flag_oe,
    input wire logic [3:0] sink_limit_level,
    input wire logic [6:0] ref_level
);
    logic [15:0] on_cnt;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // cycles the high side has been on so far
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            on_cnt <= 16'h0;
        else if (high_side_gate_cmd)
            on_cnt <= on_cnt + 16'h1;
        else
            on_cnt <= 16'h0;
    end

    no_overlap_a: assert property (
        !(high_side_gate_cmd && low_side_gate_cmd))
        else $error("both gates high");
    hs_dead_a: assert property (
        $rose(high_side_gate_cmd) |-> !low_side_gate_cmd &&
            !$past(low_side_gate_cmd) && !$past(low_side_gate_cmd, 2))
        else $error("high side rose too soon");
    ls_dead_a: assert property (
        $rose(low_side_gate_cmd) |-> !high_side_gate_cmd &&
            !$past(high_side_gate_cmd) && !$past(high_side_gate_cmd, 2))
        else $error("low side rose too soon");
    max_duty_a: assert property (
        high_side_gate_cmd |-> on_cnt < MAX_ON)
        else $error("high side beyond max duty");
    lock_off_a: assert property (
        supply_lockout [*4] |-> !high_side_gate_cmd && !low_side_gate_cmd)
        else $error("switching in lockout");
    therm_off_a: assert property (
        thermal_shdn_in [*4] |-> !high_side_gate_cmd && !low_side_gate_cmd)
        else $error("switching in thermal shutdown");
    valley_skip_a: assert property (
        valley_lim_in [*6] |-> !$rose(high_side_gate_cmd))
        else $error("high side on during valley limit");
    sink_cut_a: assert property (
        sink_lim_in [*5] ##0 low_side_gate_cmd |=> !low_side_gate_cmd)
        else $error("low side kept on at sink limit");
    pg_low_a: assert property (
        fb_below_90_in [*5] |-> output_ok_flag_oe && !output_ok_flag_o)
        else $error("power good not pulled low");
    sink_ramp_a: assert property (
        sink_limit_level > $past(sink_limit_level) |->
            sink_limit_level == $past(sink_limit_level) + 4'h1)
        else $error("sink limit jumped");
    ref_step_a: assert property (
        ref_level > $past(ref_level) |-> ref_level == $past(ref_level) + 7'h1)
        else $error("reference jumped");
endmodule

bind bss_core bss_core_asserts #(.MAX_ON(MAX_ON)) i_bss_core_asserts (.*);
`default_nettype wire

// file: tb/bss_plant.sv
// model of the power stage feedback and pwm comparator
`timescale 1ns/100ps
`default_nettype none
// ==========
// plant
module bss_plant (
    input  wire logic       clk_sys,
    input  wire logic       high_side_gate_cmd,
    input  wire logic       low_side_gate_cmd,
    input  wire logic [7:0] pwm_len,
    output logic            hs_off_fb,
    output logic            ls_off_fb,
    output logic            pwm_on_in
);
    logic [7:0] on_clk;

    initial begin
        hs_off_fb = 1'b1;
        ls_off_fb = 1'b1;
        on_clk = 8'h0;
    end

    // off status lags the gate by a clock
    always @(posedge clk_sys) begin
        hs_off_fb <= !high_side_gate_cmd;
        ls_off_fb <= !low_side_gate_cmd;
        on_clk <= high_side_gate_cmd ? on_clk + 8'h1 : 8'h0;
    end

    // comparator trips pwm_len clocks in; 8'hff never trips
    assign pwm_on_in = (on_clk < pwm_len);
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the buck soft-start pwm sequencer
`timescale 1ns/100ps
`default_nettype none
`include "bss_defines.vh"
// ==========
// bench top
module testbench;
    localparam int SW = 24;
    localparam int MAXON = 10;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0, enable_in = 1'b0, valley_lim_in = 1'b0;
    logic        sink_lim_in = 1'b0, fb_above_93_in = 1'b0;
    logic        fb_below_90_in = 1'b1, ref_above_fb_in = 1'b0;
    logic        supply_lockout = 1'b0, thermal_shdn_in = 1'b0;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic        pwm_on_in, hs_off_fb, ls_off_fb, avs_waitrequest;
    logic        high_side_gate_cmd, low_side_gate_cmd;
    logic        output_ok_flag_o, output_ok_flag_oe;
    logic [3:0]  avs_address = 4'h0, sink_limit_level;
    logic [6:0]  ref_level, lv;
    logic [7:0]  pwm_len = 8'h2;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
    int          error_cnt = 0;
    int          checks = 0;
    int          hr, lr, lh, n;

    always #2.5 clk_sys = ~clk_sys;

    bss_core #(.SW_PERIOD(SW), .MAX_ON(MAXON), .OFF_CYC(64)) i_bss_core (
        .*, .avs_byteenable(4'hf)
    );

    bss_plant i_bss_plant (.*);

    // ==========
    // helpers
    task conclude;
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        n = 0;
        @(posedge clk_sys);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= wd;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            conclude();
        end
    endtask

    task tk(input int nt);
        repeat (nt * SW) @(posedge clk_sys);
    endtask

    // counts gate rises and low-side on cycles over nt ticks
    task meas(input int nt);
        logic ph, pl;
        ph = high_side_gate_cmd;
        pl = low_side_gate_cmd;
        hr = 0;
        lr = 0;
        lh = 0;
        repeat (nt * SW) begin
            @(posedge clk_sys);
            if (high_side_gate_cmd === 1'b1 && ph !== 1'b1) hr++;
            if (low_side_gate_cmd === 1'b1 && pl !== 1'b1) lr++;
            if (low_side_gate_cmd !== 1'b0) lh++;
            ph = high_side_gate_cmd;
            pl = low_side_gate_cmd;
        end
    endtask

    // ==========
    // scenarios
    task t_regs;
        bus(1'b0, `BSS_OFS_CTRL, 32'h0);
        chk("ctrl", 32'h1, rdat);
        bus(1'b0, `BSS_OFS_FAULT, 32'h0);
        chk("fault", 32'h0, rdat);
        bus(1'b0, 4'hc, 32'h0);
        chk("unmapped", 32'h0, rdat);
        bus(1'b1, `BSS_OFS_CTRL, 32'h0);
        bus(1'b0, `BSS_OFS_CTRL, 32'h0);
        chk("ctrl_wr", 32'h0, rdat);
        bus(1'b1, `BSS_OFS_CTRL, 32'h1);
    endtask

    // output above set point: no switching during the ramp
    task t_start;
        enable_in <= 1'b1;
        meas(2040);
        chk("gates_quiet", 32'h0, hr + lr + lh);
        chk("ramp_mid", 32'h1, ref_level < 7'h40);
        tk(20);
        chk("ramp_top", 32'h40, ref_level);
        tk(260);
        chk("sink_top", `BSS_SINK_MAX, sink_limit_level);
    endtask

    task t_run;
        ref_above_fb_in <= 1'b1;
        fb_above_93_in <= 1'b1;
        fb_below_90_in <= 1'b0;
        tk(4);
        meas(20);
        chk("hs_pulses", 32'd20, hr);
        chk("ls_pulses", 32'd20, lr);
        chk("pg_release", 32'h0, output_ok_flag_oe);
        pwm_len <= 8'hff;
        tk(2);
        meas(10);
        chk("maxduty_pulses", 32'd10, hr);
        pwm_len <= 8'h2;
    endtask

    task t_fault;
        valley_lim_in <= 1'b1;
        tk(1);
        meas(2);
        chk("valley_skip", 32'h0, hr);
        chk("valley_ls_on", 2 * SW, lh);
        valley_lim_in <= 1'b0;
        sink_lim_in <= 1'b1;
        tk(8);
        meas(2);
        chk("sink_cut", 32'h1, lh <= 4);
        sink_lim_in <= 1'b0;
        bus(1'b0, `BSS_OFS_FAULT, 32'h0);
        chk("sink_flag", 32'h1, rdat[`BSS_FLT_SINK_BIT]);
        bus(1'b1, `BSS_OFS_FAULT, 32'h4);
        bus(1'b0, `BSS_OFS_FAULT, 32'h0);
        chk("sink_w1c", 32'h0, rdat[`BSS_FLT_SINK_BIT]);
        thermal_shdn_in <= 1'b1;
        tk(1);
        meas(2);
        chk("therm_off", 32'h0, hr + lh);
        chk("therm_ref", 32'h0, ref_level);
        thermal_shdn_in <= 1'b0;
        tk(192);
        meas(4);
        chk("therm_restart", 32'h1, hr > 0);
    endtask

    // soft-stop from a low step, then gates off
    task t_stop;
        lv = ref_level;
        enable_in <= 1'b0;
        meas(40);
        chk("stop_step", 32'h1, ref_level < lv);
        n = 0;
        while (ref_level !== 7'h0 && n < 400 * SW) begin
            @(posedge clk_sys);
            n++;
        end
        if (ref_level !== 7'h0) begin
            error_cnt++;
            conclude();
        end
        tk(2);
        meas(4);
        chk("stop_off", 32'h0, hr + lh);
    endtask

    task t_prot;
        enable_in <= 1'b1;
        tk(40);
        supply_lockout <= 1'b1;
        tk(1);
        meas(3);
        chk("lock_off", 32'h0, hr + lh);
        supply_lockout <= 1'b0;
        tk(40);
        valley_lim_in <= 1'b1;
        tk(10);
        valley_lim_in <= 1'b0;
        meas(20);
        chk("hiccup_off", 32'h0, hr + lh);
        chk("hiccup_pg", 32'h1, output_ok_flag_oe);
        bus(1'b0, `BSS_OFS_FAULT, 32'h0);
        chk("hiccup_flag", 32'h1, rdat[`BSS_FLT_HIC_BIT]);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("rst_gates", 32'h0, {high_side_gate_cmd, low_side_gate_cmd});
        bus(1'b0, `BSS_OFS_CTRL, 32'h0);
        chk("rst_ctrl", 32'h1, rdat);
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_start();
        t_run();
        t_fault();
        t_stop();
        t_prot();
        conclude();
    end
endmodule
`default_nettype wire
